// File: verilog/zau_pkg.sv
// Package of constants and types for the zone access unit
package zau_pkg;

   // ==========================================================
   // Register map (byte addresses on the register port)
   // ==========================================================
   localparam logic [15:0] ZAU_WRITE_CYCLE_MODE_ADDR = 16'hf900;
   localparam logic [15:0] ZAU_IO_ZONE_TIMING_ADDR = 16'hf902;
   localparam logic [15:0] ZAU_STATIC_ZONE0_ADDR = 16'hf904;
   localparam logic [15:0] ZAU_STATIC_ZONE1_ADDR = 16'hf906;
   localparam logic [15:0] ZAU_UNIT_STATUS_ADDR = 16'hf908;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [2:0] ZAU_WRITE_CYCLE_MODE_RESET = 3'h7;
   localparam logic [15:0] ZAU_ZONE_TIMING_RESET = 16'h069f;
   localparam logic [15:0] ZAU_READ_ZERO = 16'h0000;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int ZAU_EARLY_WRITE_BIT = 0;
   localparam int ZAU_WAIT_LSB = 0;
   localparam int ZAU_WAIT_MSB = 2;
   localparam int ZAU_HOLD_LSB = 3;
   localparam int ZAU_HOLD_MSB = 4;
   localparam int ZAU_BUS_WIDTH_BIT = 7;
   localparam int ZAU_POST_IDLE_BIT = 10;
   localparam int ZAU_PRE_IDLE_BIT = 11;
   localparam int ZAU_FAST_READ_BIT = 12;
   localparam int ZAU_MODE_MSB = 2;

   // ==========================================================
   // Zones and address decode (top two address bits)
   // ==========================================================
   typedef enum logic [1:0] {
      ZAU_ZONE_FLASH,
      ZAU_ZONE_BOOT,
      ZAU_ZONE_IO
   } zau_zone_e;
   localparam logic [1:0] ZAU_SEL_BOOT = 2'h2;
   localparam logic [1:0] ZAU_SEL_IO = 2'h3;

   // ==========================================================
   // Cycle types and basic lengths after the address clock
   // ==========================================================
   typedef enum logic [1:0] {
      ZAU_CYC_NORMAL_READ,
      ZAU_CYC_FAST_READ,
      ZAU_CYC_EARLY_WRITE,
      ZAU_CYC_LATE_WRITE
   } zau_cycle_e;
   localparam logic [2:0] ZAU_NORMAL_READ_REST = 3'h1;
   localparam logic [2:0] ZAU_LATE_WRITE_REST = 3'h1;
   localparam logic [2:0] ZAU_EARLY_WRITE_REST = 3'h2;
   localparam logic [2:0] ZAU_CNT_ZERO = 3'h0;
   localparam logic [2:0] ZAU_CNT_ONE = 3'h1;

endpackage : zau_pkg

// File: verilog/zau_zone_if.sv
// Interface carrying one zone's decoded timing fields
`timescale 1ns/1ns
`default_nettype none

interface zau_zone_if;
   logic [15:0] value;
   logic [2:0] wait_cycles;
   logic [1:0] hold_cycles;
   logic bus_width;
   logic fast_read;
   logic pre_idle;
   logic post_idle;

   modport cfg (
      output value,
      output wait_cycles,
      output hold_cycles,
      output bus_width,
      output fast_read,
      output pre_idle,
      output post_idle
   );
   modport user (
      input value,
      input wait_cycles,
      input hold_cycles,
      input bus_width,
      input fast_read,
      input pre_idle,
      input post_idle
   );
endinterface : zau_zone_if

`default_nettype wire

// File: verilog/zau_zone_cfg.sv
// One zone timing register with its field decode
`timescale 1ns/1ns
`default_nettype none

module zau_zone_cfg #(
   parameter logic [15:0] REG_ADDR = zau_pkg::ZAU_IO_ZONE_TIMING_ADDR,
   parameter bit STATIC_ZONE = 1'b0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] wr_addr,
   input wire logic [15:0] wr_data,
   input wire logic wr_en,
   zau_zone_if.cfg zone
);
   import zau_pkg::*;

   logic [15:0] cfg_reg;

   // ==========================================================
   // Storage, loads its documented value at reset
   // ==========================================================
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_reg <= ZAU_ZONE_TIMING_RESET;
      end else if (wr_en && wr_addr == REG_ADDR) begin
         cfg_reg <= wr_data;
      end
   end

   // Field decode; the I/O zone has no fast read or pre-idle bits
   assign zone.value = cfg_reg;
   assign zone.wait_cycles = cfg_reg[ZAU_WAIT_MSB:ZAU_WAIT_LSB];
   assign zone.hold_cycles = cfg_reg[ZAU_HOLD_MSB:ZAU_HOLD_LSB];
   assign zone.bus_width = cfg_reg[ZAU_BUS_WIDTH_BIT];
   assign zone.post_idle = cfg_reg[ZAU_POST_IDLE_BIT];
   assign zone.pre_idle = STATIC_ZONE && cfg_reg[ZAU_PRE_IDLE_BIT];
   assign zone.fast_read = STATIC_ZONE && cfg_reg[ZAU_FAST_READ_BIT];

endmodule : zau_zone_cfg

`default_nettype wire

// File: verilog/zau_zone_access_unit.sv
// Zone access unit: cycle type, wait, hold and idle sequencing
//
// Overview of operation
// - Four cycle types: normal read, fast read, early write, late write.
// - Cycle type follows direction, target zone and programmed access types.
// - Basic normal read takes two clocks, basic fast read one clock.
// - After reset reads use the normal two-clock type.
// - Basic late write takes two clocks, early write three clocks.
// - Early write after reset; software should then select late write.
// - Wait cycles follow the address clock, giving memory more time.
// - Hold cycles end the access, keeping write data driven.
// - Mode bit 0 picks late write when 0, early write when 1.
// - Mode register resets to 07 hex; software rewrites it to 06.
// - I/O wait field adds zero to seven wait cycles.
// - I/O hold field adds zero to three hold cycles.
// - Bus width bit: 0 byte, 1 word; software selects word.
// - Post-idle adds one idle clock when the next access changes zone.
// - I/O timing register sits at F902 and resets to 069F.
// - Each access uses its zone's timing and drives matching strobes.
// - Fast read ignores the zone's wait and hold; done in one clock.
// - Pre-idle adds one idle clock before an access changing zone.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

module zau_zone_access_unit (
   input wire logic SYS_CLK,
   input wire logic RESET,
   // Register port
   input wire logic [15:0] REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [15:0] REG_RDATA,
   // Core bus side
   input wire logic CORE_REQ,
   input wire logic CORE_WRITE,
   input wire logic [15:0] CORE_ADDR,
   input wire logic [15:0] CORE_WDATA,
   output logic CORE_DONE,
   output logic [15:0] CORE_RDATA,
   // On-chip module side
   output logic [15:0] MEM_ADDR,
   output logic [2:0] MEM_ZONE_SEL,
   output logic MEM_RD,
   output logic MEM_WR,
   output logic [15:0] MEM_WDATA,
   output logic MEM_WDATA_OE,
   output logic MEM_BYTE_MODE,
   output logic MEM_IDLE,
   output zau_pkg::zau_cycle_e MEM_CYCLE_TYPE,
   input wire logic [15:0] MEM_RDATA
);
   import zau_pkg::*;

   // ==========================================================
   // Declarations
   // ==========================================================
   typedef enum logic [2:0] {
      ZAU_ST_IDLE,
      ZAU_ST_PRE,
      ZAU_ST_ADDR,
      ZAU_ST_WAIT,
      ZAU_ST_BASIC,
      ZAU_ST_HOLD
   } zau_state_e;

   zau_state_e state_reg;
   zau_state_e state_next;
   logic [2:0] cnt_reg;
   logic [2:0] cnt_next;
   logic [2:0] write_mode_reg;
   logic [15:0] rdata_reg;

   // Latched access description
   logic [15:0] addr_reg;
   logic [15:0] wdata_reg;
   zau_zone_e zone_reg;
   zau_cycle_e cycle_reg;
   logic [2:0] wait_reg;
   logic [1:0] hold_reg;
   logic [2:0] rest_reg;
   logic byte_mode_reg;
   logic done_reg;

   // Zone history for idle insertion
   zau_zone_e last_zone_reg;
   logic last_valid_reg;
   logic last_post_reg;

   // Request decode
   zau_zone_e req_zone;
   zau_cycle_e req_cycle;
   logic req_fast;
   logic req_pre;
   logic req_bw;
   logic [2:0] req_wait;
   logic [1:0] req_hold;
   logic [2:0] req_rest;
   logic [1:0] req_idles;
   logic zone_change;
   logic accept;
   logic finish;
   logic wr_cycle;

   zau_zone_if io_zone ();
   zau_zone_if flash_zone ();
   zau_zone_if boot_zone ();

   // ==========================================================
   // Zone timing registers
   // ==========================================================
   // I/O zone: no fast read, no pre-idle
   zau_zone_cfg #(
      .REG_ADDR(ZAU_IO_ZONE_TIMING_ADDR),
      .STATIC_ZONE(1'b0)
   ) u_io_cfg (
      .clk(SYS_CLK),
      .rst(RESET),
      .wr_addr(REG_ADDR),
      .wr_data(REG_WDATA),
      .wr_en(REG_WR),
      .zone(io_zone.cfg)
   );

   // Program flash zone
   zau_zone_cfg #(
      .REG_ADDR(ZAU_STATIC_ZONE0_ADDR),
      .STATIC_ZONE(1'b1)
   ) u_flash_cfg (
      .clk(SYS_CLK),
      .rst(RESET),
      .wr_addr(REG_ADDR),
      .wr_data(REG_WDATA),
      .wr_en(REG_WR),
      .zone(flash_zone.cfg)
   );

   // Boot ROM zone
   zau_zone_cfg #(
      .REG_ADDR(ZAU_STATIC_ZONE1_ADDR),
      .STATIC_ZONE(1'b1)
   ) u_boot_cfg (
      .clk(SYS_CLK),
      .rst(RESET),
      .wr_addr(REG_ADDR),
      .wr_data(REG_WDATA),
      .wr_en(REG_WR),
      .zone(boot_zone.cfg)
   );

   // ==========================================================
   // Write cycle mode register
   // ==========================================================
   // Bits 1 and 2 are stored only so software reads back what it wrote
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         write_mode_reg <= ZAU_WRITE_CYCLE_MODE_RESET;
      end else if (REG_WR && REG_ADDR == ZAU_WRITE_CYCLE_MODE_ADDR) begin
         write_mode_reg <= REG_WDATA[ZAU_MODE_MSB:0];
      end
   end

   // ==========================================================
   // Register read port, data one clock after the strobe
   // ==========================================================
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         rdata_reg <= ZAU_READ_ZERO;
      end else if (REG_RD) begin
         case (REG_ADDR)
            ZAU_WRITE_CYCLE_MODE_ADDR: begin
               rdata_reg <= {13'h0000, write_mode_reg};
            end
            ZAU_IO_ZONE_TIMING_ADDR: begin
               rdata_reg <= io_zone.value;
            end
            ZAU_STATIC_ZONE0_ADDR: begin
               rdata_reg <= flash_zone.value;
            end
            ZAU_STATIC_ZONE1_ADDR: begin
               rdata_reg <= boot_zone.value;
            end
            ZAU_UNIT_STATUS_ADDR: begin
               // Busy, current zone, last zone and its post-idle flag
               rdata_reg <= {10'h000, last_post_reg, last_zone_reg,
                             zone_reg, state_reg != ZAU_ST_IDLE};
            end
            default: begin
               rdata_reg <= ZAU_READ_ZERO;
            end
         endcase
      end else begin
         rdata_reg <= ZAU_READ_ZERO;
      end
   end

   assign REG_RDATA = rdata_reg;

   // ==========================================================
   // Request decode: zone, cycle type and timing
   // ==========================================================
   always_comb begin
      case (CORE_ADDR[15:14])
         ZAU_SEL_IO: begin
            req_zone = ZAU_ZONE_IO;
         end
         ZAU_SEL_BOOT: begin
            req_zone = ZAU_ZONE_BOOT;
         end
         default: begin
            req_zone = ZAU_ZONE_FLASH;
         end
      endcase
   end

   // Pick the selected zone's fields
   always_comb begin
      case (req_zone)
         ZAU_ZONE_IO: begin
            req_fast = io_zone.fast_read;
            req_pre = io_zone.pre_idle;
            req_bw = io_zone.bus_width;
            req_wait = io_zone.wait_cycles;
            req_hold = io_zone.hold_cycles;
         end
         ZAU_ZONE_BOOT: begin
            req_fast = boot_zone.fast_read;
            req_pre = boot_zone.pre_idle;
            req_bw = boot_zone.bus_width;
            req_wait = boot_zone.wait_cycles;
            req_hold = boot_zone.hold_cycles;
         end
         default: begin
            req_fast = flash_zone.fast_read;
            req_pre = flash_zone.pre_idle;
            req_bw = flash_zone.bus_width;
            req_wait = flash_zone.wait_cycles;
            req_hold = flash_zone.hold_cycles;
         end
      endcase
   end

   // Cycle type from direction, zone and programmed types
   always_comb begin
      if (CORE_WRITE) begin
         if (write_mode_reg[ZAU_EARLY_WRITE_BIT]) begin
            req_cycle = ZAU_CYC_EARLY_WRITE;
            req_rest = ZAU_EARLY_WRITE_REST;
         end else begin
            req_cycle = ZAU_CYC_LATE_WRITE;
            req_rest = ZAU_LATE_WRITE_REST;
         end
      end else if (req_fast) begin
         req_cycle = ZAU_CYC_FAST_READ;
         req_rest = ZAU_CNT_ZERO;
      end else begin
         req_cycle = ZAU_CYC_NORMAL_READ;
         req_rest = ZAU_NORMAL_READ_REST;
      end
   end

   // Idle clocks only between accesses to different zones
   assign zone_change = last_valid_reg && (req_zone != last_zone_reg);
   assign req_idles = zone_change ?
      {1'b0, last_post_reg} + {1'b0, req_pre} : 2'h0;

   // Done pulse blocks a second take of the same held request
   assign accept = (state_reg == ZAU_ST_IDLE) && CORE_REQ && !done_reg;

   // ==========================================================
   // Access sequencer
   // ==========================================================
   // Length = idles + address + waits + rest + holds, or idles + address for fast read
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      finish = 1'b0;
      case (state_reg)
         ZAU_ST_IDLE: begin
            if (accept) begin
               if (req_idles != 2'h0) begin
                  state_next = ZAU_ST_PRE;
                  cnt_next = {1'b0, req_idles} - ZAU_CNT_ONE;
               end else begin
                  state_next = ZAU_ST_ADDR;
               end
            end
         end
         ZAU_ST_PRE: begin
            if (cnt_reg == ZAU_CNT_ZERO) begin
               state_next = ZAU_ST_ADDR;
            end else begin
               cnt_next = cnt_reg - ZAU_CNT_ONE;
            end
         end
         ZAU_ST_ADDR: begin
            if (cycle_reg == ZAU_CYC_FAST_READ) begin
               // Wait and hold fields do not apply here
               state_next = ZAU_ST_IDLE;
               finish = 1'b1;
            end else if (wait_reg != ZAU_CNT_ZERO) begin
               state_next = ZAU_ST_WAIT;
               cnt_next = wait_reg - ZAU_CNT_ONE;
            end else begin
               state_next = ZAU_ST_BASIC;
               cnt_next = rest_reg - ZAU_CNT_ONE;
            end
         end
         ZAU_ST_WAIT: begin
            if (cnt_reg == ZAU_CNT_ZERO) begin
               state_next = ZAU_ST_BASIC;
               cnt_next = rest_reg - ZAU_CNT_ONE;
            end else begin
               cnt_next = cnt_reg - ZAU_CNT_ONE;
            end
         end
         ZAU_ST_BASIC: begin
            if (cnt_reg != ZAU_CNT_ZERO) begin
               cnt_next = cnt_reg - ZAU_CNT_ONE;
            end else if (hold_reg != 2'h0) begin
               state_next = ZAU_ST_HOLD;
               cnt_next = {1'b0, hold_reg} - ZAU_CNT_ONE;
            end else begin
               state_next = ZAU_ST_IDLE;
               finish = 1'b1;
            end
         end
         ZAU_ST_HOLD: begin
            if (cnt_reg == ZAU_CNT_ZERO) begin
               state_next = ZAU_ST_IDLE;
               finish = 1'b1;
            end else begin
               cnt_next = cnt_reg - ZAU_CNT_ONE;
            end
         end
         default: begin
            state_next = ZAU_ST_IDLE;
            cnt_next = ZAU_CNT_ZERO;
         end
      endcase
   end

   // State and counter
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         state_reg <= ZAU_ST_IDLE;
         cnt_reg <= ZAU_CNT_ZERO;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // Latch the access and its zone timing on acceptance
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         addr_reg <= 16'h0000;
         wdata_reg <= 16'h0000;
         zone_reg <= ZAU_ZONE_FLASH;
         cycle_reg <= ZAU_CYC_NORMAL_READ;
         wait_reg <= ZAU_CNT_ZERO;
         hold_reg <= 2'h0;
         rest_reg <= ZAU_CNT_ZERO;
         byte_mode_reg <= 1'b0;
      end else if (accept) begin
         addr_reg <= CORE_ADDR;
         wdata_reg <= CORE_WDATA;
         zone_reg <= req_zone;
         cycle_reg <= req_cycle;
         wait_reg <= req_wait;
         hold_reg <= req_hold;
         rest_reg <= req_rest;
         byte_mode_reg <= !req_bw;
      end
   end

   // Remember the zone just used and whether it asked for post-idle
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         last_zone_reg <= ZAU_ZONE_FLASH;
         last_valid_reg <= 1'b0;
         last_post_reg <= 1'b0;
      end else if (finish) begin
         last_zone_reg <= zone_reg;
         last_valid_reg <= 1'b1;
         case (zone_reg)
            ZAU_ZONE_IO: begin
               last_post_reg <= io_zone.post_idle;
            end
            ZAU_ZONE_BOOT: begin
               last_post_reg <= boot_zone.post_idle;
            end
            default: begin
               last_post_reg <= flash_zone.post_idle;
            end
         endcase
      end
   end

   // Read data taken at the last data clock, done in the clock after the access ends
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         CORE_RDATA <= 16'h0000;
         done_reg <= 1'b0;
      end else begin
         done_reg <= finish;
         if (!wr_cycle && capture_now()) begin
            CORE_RDATA <= MEM_RDATA;
         end
      end
   end

   // Reads capture at the end of the address or final basic clock
   function automatic logic capture_now();
      logic fast_end;
      logic norm_end;
      fast_end = (state_reg == ZAU_ST_ADDR) &&
                 (cycle_reg == ZAU_CYC_FAST_READ);
      norm_end = (state_reg == ZAU_ST_BASIC) && (cnt_reg == ZAU_CNT_ZERO);
      return fast_end || norm_end;
   endfunction : capture_now

   // A net, not a function, so the strobes follow a new cycle type
   assign wr_cycle = (cycle_reg == ZAU_CYC_EARLY_WRITE) ||
                     (cycle_reg == ZAU_CYC_LATE_WRITE);

   assign CORE_DONE = done_reg;

   // ==========================================================
   // Module-side strobes
   // ==========================================================
   // Address and zone stand from the address clock to the last hold
   always_comb begin
      MEM_ZONE_SEL = 3'h0;
      if (state_reg != ZAU_ST_IDLE && state_reg != ZAU_ST_PRE) begin
         MEM_ZONE_SEL[zone_reg] = 1'b1;
      end
   end

   assign MEM_ADDR = addr_reg;
   assign MEM_WDATA = wdata_reg;
   assign MEM_BYTE_MODE = byte_mode_reg;
   assign MEM_CYCLE_TYPE = cycle_reg;
   assign MEM_IDLE = (state_reg == ZAU_ST_PRE);

   // Read strobe over address, wait and basic clocks
   assign MEM_RD = !wr_cycle &&
                   (state_reg == ZAU_ST_ADDR || state_reg == ZAU_ST_WAIT ||
                    state_reg == ZAU_ST_BASIC);

   // Write strobe only in the first basic clock; early write adds a
   // recovery clock behind it
   assign MEM_WR = wr_cycle && (state_reg == ZAU_ST_BASIC) &&
                   (cnt_reg == rest_reg - ZAU_CNT_ONE);

   // Write data driven through the hold clocks
   assign MEM_WDATA_OE = wr_cycle &&
                         (state_reg == ZAU_ST_ADDR ||
                          state_reg == ZAU_ST_WAIT ||
                          state_reg == ZAU_ST_BASIC ||
                          state_reg == ZAU_ST_HOLD);

endmodule : zau_zone_access_unit

`default_nettype wire

// File: tb/zau_zone_access_unit_asserts.sv
// Checker of the zone access unit port timing
`timescale 1ns/1ns
`default_nettype none
module zau_zone_access_unit_asserts
   import zau_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic REG_RD,
   input wire logic [15:0] REG_RDATA,
   input wire logic CORE_DONE,
   input wire logic [2:0] MEM_ZONE_SEL,
   input wire logic MEM_RD,
   input wire logic MEM_WR,
   input wire logic MEM_WDATA_OE,
   input wire logic MEM_IDLE,
   input var zau_pkg::zau_cycle_e MEM_CYCLE_TYPE
);
   // ==========================================================
   // Clocking
   // ==========================================================
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RESET);
   // Fast read ends right after its address clock
   sequence s_fast_end;
      CORE_DONE && !MEM_RD;
   endsequence
   property p_fast;
      $rose(MEM_RD) && MEM_CYCLE_TYPE == ZAU_CYC_FAST_READ |=> s_fast_end;
   endproperty
   a_fast: assert property (p_fast) else $error("fast read too long");
   property p_norm;
      $rose(MEM_RD) && MEM_CYCLE_TYPE == ZAU_CYC_NORMAL_READ |=> MEM_RD;
   endproperty
   a_norm: assert property (p_norm) else $error("normal read short");
   property p_wr_one;
      MEM_WR |=> !MEM_WR;
   endproperty
   a_wr_one: assert property (p_wr_one) else $error("long strobe");
   property p_wr_oe;
      MEM_WR |-> MEM_WDATA_OE && (MEM_CYCLE_TYPE == ZAU_CYC_EARLY_WRITE
         || MEM_CYCLE_TYPE == ZAU_CYC_LATE_WRITE);
   endproperty
   a_wr_oe: assert property (p_wr_oe) else $error("write type");
   property p_hold_done;
      $fell(MEM_WDATA_OE) |-> CORE_DONE;
   endproperty
   a_hold_done: assert property (p_hold_done) else $error("hold end");
   property p_rd_oe;
      MEM_RD |-> !MEM_WDATA_OE;
   endproperty
   a_rd_oe: assert property (p_rd_oe) else $error("data on read");
   property p_idle;
      MEM_IDLE |-> !MEM_RD && !MEM_WR && MEM_ZONE_SEL == 3'h0;
   endproperty
   a_idle: assert property (p_idle) else $error("busy idle");
   property p_sel;
      MEM_RD || MEM_WR |-> $onehot(MEM_ZONE_SEL);
   endproperty
   a_sel: assert property (p_sel) else $error("zone select");
   property p_done;
      CORE_DONE |=> !CORE_DONE;
   endproperty
   a_done: assert property (p_done) else $error("done width");
   property p_reg;
      !REG_RD |=> REG_RDATA == 16'h0000;
   endproperty
   a_reg: assert property (p_reg) else $error("stale data");
endmodule : zau_zone_access_unit_asserts
bind zau_zone_access_unit zau_zone_access_unit_asserts
   u_zau_zone_access_unit_asserts (.SYS_CLK, .RESET, .REG_RD, .REG_RDATA,
   .CORE_DONE, .MEM_ZONE_SEL, .MEM_RD, .MEM_WR, .MEM_WDATA_OE, .MEM_IDLE,
   .MEM_CYCLE_TYPE);
`default_nettype wire

// File: tb/zau_mem_model.sv
// Behavioural model of the on-chip memory zones
`timescale 1ns/1ns
`default_nettype none
module zau_mem_model (
   input wire logic [15:0] mem_addr,
   input wire logic mem_rd,
   output logic [15:0] mem_rdata
);
   // Released bus shows the inverse so a late sample is caught
   assign mem_rdata = mem_rd ? mem_addr ^ 16'h5a5a : ~(mem_addr ^ 16'h5a5a);
endmodule : zau_mem_model
`default_nettype wire

// File: tb/zau_zone_access_unit_test.sv
// Self-checking bench of the zone access unit
`timescale 1ns/1ns
`default_nettype none
module zau_zone_access_unit_test;
   import zau_pkg::*;
   logic SYS_CLK = 1'b0, RESET = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0;
   logic CORE_REQ = 1'b0, CORE_WRITE = 1'b0;
   logic [15:0] REG_ADDR = 16'h0000, REG_WDATA = 16'h0000;
   logic [15:0] CORE_ADDR = 16'h0000, CORE_WDATA = 16'h0000;
   logic [15:0] REG_RDATA, CORE_RDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA;
   logic [2:0] MEM_ZONE_SEL;
   logic CORE_DONE, MEM_RD, MEM_WR, MEM_WDATA_OE, MEM_BYTE_MODE, MEM_IDLE;
   zau_cycle_e MEM_CYCLE_TYPE;
   int miscompares = 0, n_tests = 0;
   // ==========================================================
   // Design and memory model
   // ==========================================================
   zau_zone_access_unit u_zau_zone_access_unit (.SYS_CLK, .RESET,
      .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .CORE_REQ,
      .CORE_WRITE, .CORE_ADDR, .CORE_WDATA, .CORE_DONE, .CORE_RDATA,
      .MEM_ADDR, .MEM_ZONE_SEL, .MEM_RD, .MEM_WR, .MEM_WDATA,
      .MEM_WDATA_OE, .MEM_BYTE_MODE, .MEM_IDLE, .MEM_CYCLE_TYPE,
      .MEM_RDATA);
   zau_mem_model u_zau_mem_model (.mem_addr(MEM_ADDR), .mem_rd(MEM_RD),
      .mem_rdata(MEM_RDATA));
   // 25 MHz clock
   initial forever #20 SYS_CLK = ~SYS_CLK;
   // ==========================================================
   // Tasks
   // ==========================================================
   task automatic chk16(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk16
   task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge SYS_CLK);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge SYS_CLK);
      REG_WR <= 1'b0;
   endtask : reg_wr
   // Data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [15:0] a, input logic [15:0] exp);
      @(posedge SYS_CLK);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge SYS_CLK);
      REG_RD <= 1'b0;
      #1 chk16("register read", exp, REG_RDATA);
   endtask : reg_rd
   // Count cycles to done; request is held through the done cycle
   task automatic acc(input logic w, input logic [15:0] a,
      input logic [15:0] n_exp, input zau_cycle_e ty);
      logic [15:0] n;
      zau_cycle_e seen;
      n = 16'h0000;
      seen = zau_cycle_e'(~ty);
      @(posedge SYS_CLK);
      CORE_REQ <= 1'b1;
      CORE_WRITE <= w;
      CORE_ADDR <= a;
      CORE_WDATA <= ~a;
      do begin
         @(posedge SYS_CLK);
         #1 n++;
         if (MEM_RD || MEM_WR) seen = MEM_CYCLE_TYPE;
         if (MEM_WR) chk16("write data", ~a, MEM_WDATA);
         if (MEM_RD || MEM_WR)
            chk16("byte mode", 16'h0, 16'(MEM_BYTE_MODE));
      end while (CORE_DONE !== 1'b1 && n < 16'd40);
      chk16("access cycles", n_exp, n);
      chk16("cycle type", 16'(ty), 16'(seen));
      if (!w) chk16("read data", a ^ 16'h5a5a, CORE_RDATA);
      @(posedge SYS_CLK);
      CORE_REQ <= 1'b0;
   endtask : acc
   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test
   // ==========================================================
   // Sequence of tests
   // ==========================================================
   initial begin
      repeat (20) @(posedge SYS_CLK);
      RESET <= 1'b0;
      reg_rd(ZAU_WRITE_CYCLE_MODE_ADDR, 16'h0007);
      reg_rd(ZAU_IO_ZONE_TIMING_ADDR, 16'h069f);
      reg_rd(16'hf90a, 16'h0000);
      acc(1'b0, 16'h0100, 16'd13, ZAU_CYC_NORMAL_READ);
      acc(1'b1, 16'h0102, 16'd14, ZAU_CYC_EARLY_WRITE);
      reg_wr(ZAU_WRITE_CYCLE_MODE_ADDR, 16'h0006);
      reg_rd(ZAU_WRITE_CYCLE_MODE_ADDR, 16'h0006);
      acc(1'b1, 16'h0104, 16'd13, ZAU_CYC_LATE_WRITE);
      reg_wr(ZAU_STATIC_ZONE0_ADDR, 16'h009f);
      acc(1'b0, 16'h0106, 16'd13, ZAU_CYC_NORMAL_READ);
      // Every wait count with the hold counts beside it
      for (int w = 0; w < 8; w++) begin
         reg_wr(ZAU_IO_ZONE_TIMING_ADDR,
            16'h0080 | 16'(w) | 16'((w % 4) << 3));
         acc(1'b0, 16'hc000 + 16'(w), 16'(3 + w + w % 4),
            ZAU_CYC_NORMAL_READ);
         acc(1'b1, 16'hc010, 16'(3 + w + w % 4),
            ZAU_CYC_LATE_WRITE);
      end
      reg_rd(ZAU_IO_ZONE_TIMING_ADDR, 16'h009f);
      reg_wr(ZAU_STATIC_ZONE0_ADDR, 16'h109f);
      acc(1'b0, 16'h0200, 16'd2, ZAU_CYC_FAST_READ);
      // Zone changes with idle clocks on either side
      reg_wr(ZAU_STATIC_ZONE1_ADDR, 16'h0880);
      acc(1'b0, 16'h8000, 16'd4, ZAU_CYC_NORMAL_READ);
      acc(1'b0, 16'h8002, 16'd3, ZAU_CYC_NORMAL_READ);
      reg_wr(ZAU_STATIC_ZONE0_ADDR, 16'h0480);
      acc(1'b0, 16'h0300, 16'd3, ZAU_CYC_NORMAL_READ);
      acc(1'b0, 16'h8004, 16'd5, ZAU_CYC_NORMAL_READ);
      finish_test();
   end
   // Watchdog well beyond the expected run length
   initial begin
      #400000;
      miscompares++;
      finish_test();
   end
endmodule : zau_zone_access_unit_test
`default_nettype wire
